/* File: rtl/mabe_pkg.sv */
// shared types, constants and arithmetic helpers of the execute unit
package mabe_pkg;

   // status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // values after reset
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET    = 16'h0000;

   // cycle counts per operation class
   localparam logic [2:0] CYC_ALU        = 3'h1;
   localparam logic [2:0] CYC_PAIR       = 3'h2;
   localparam logic [2:0] CYC_MUL        = 3'h2;
   localparam logic [2:0] CYC_REL_JUMP   = 3'h2;
   localparam logic [2:0] CYC_PTR_JUMP   = 3'h2;
   localparam logic [2:0] CYC_DIR_JUMP   = 3'h3;
   localparam logic [2:0] CYC_REL_CALL   = 3'h3;
   localparam logic [2:0] CYC_PTR_CALL   = 3'h3;
   localparam logic [2:0] CYC_DIR_CALL   = 3'h4;
   localparam logic [2:0] CYC_RETURN     = 3'h4;
   localparam logic [2:0] CYC_BR_TAKEN   = 3'h2;
   localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
   localparam logic [2:0] CYC_SKIP_LONG  = 3'h3;

   // pc steps
   localparam logic [15:0] PC_STEP       = 16'h0001;
   localparam logic [15:0] PC_CALL_LONG  = 16'h0002;
   localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
   localparam logic [15:0] PC_SKIP_LONG  = 16'h0003;

   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] INC_OVF  = 8'h80;
   localparam logic [7:0] DEC_OVF  = 8'h7F;

   typedef enum logic [5:0] {
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW,
      OP_AND, OP_OR, OP_EOR, OP_CLR_MASK, OP_FILL_ONES, OP_ZS_CHECK,
      OP_INC, OP_DEC, OP_COM, OP_NEG, OP_ADD_PAIR, OP_SUB_PAIR,
      OP_MUL_U, OP_MUL_S, OP_MUL_MIX, OP_FRAC_U, OP_FRAC_S, OP_FRAC_MIX,
      OP_REL_JUMP, OP_PTR_JUMP, OP_DIR_JUMP,
      OP_REL_CALL, OP_PTR_CALL, OP_DIR_CALL, OP_RETURN, OP_INT_RETURN,
      OP_CMP_SKIP, OP_CMP, OP_CMP_BORROW,
      OP_SKIP_REG_LOW, OP_SKIP_REG_HIGH, OP_SKIP_IO_LOW, OP_SKIP_IO_HIGH,
      OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
      OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT
   } mabe_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } mabe_fsm_t;

   typedef struct packed {
      mabe_op_t    op;
      logic [7:0]  opa;
      logic [7:0]  opb;
      logic [15:0] word;
      logic [2:0]  bit_sel;
      logic [11:0] offset;
      logic [15:0] target;
      logic        next_long;
   } mabe_req_t;

   typedef struct packed {
      logic        rd_we;
      logic [7:0]  rd_data;
      logic        pair_we;
      logic [15:0] pair_data;
      logic        prod_we;
      logic [15:0] prod_data;
      logic        push_we;
      logic [15:0] push_addr;
      logic        pop;
   } mabe_wb_t;

   typedef struct packed {
      mabe_fsm_t   state;
      logic [2:0]  cnt;
      logic [7:0]  flags;
      logic [15:0] pc;
      logic [7:0]  pend_flags;
      logic [15:0] pend_pc;
      mabe_wb_t    pend_wb;
      mabe_wb_t    wb;
      logic        done;
   } mabe_state_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       h;
      logic       v;
   } mabe_alu_t;

   function automatic mabe_alu_t mabe_add8(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin);
      logic [8:0] s;
      mabe_alu_t  r;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      r.res = s[7:0];
      r.c = s[8];
      r.h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
      r.v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
      return r;
   endfunction : mabe_add8

   function automatic mabe_alu_t mabe_sub8(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin);
      logic [8:0] s;
      mabe_alu_t  r;
      s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      r.res = s[7:0];
      r.c = s[8];
      r.h = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
      r.v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
      return r;
   endfunction : mabe_sub8

   function automatic logic [15:0] mabe_rel_target(input logic [15:0] pc,
                                                   input logic [11:0] off);
      return pc + {{4{off[11]}}, off} + PC_STEP;
   endfunction : mabe_rel_target

endpackage : mabe_pkg

/* File: rtl/mabe_mul.sv */
// 8x8 multiplier with signed, mixed and fractional variants
module mabe_mul
   import mabe_pkg::*;
(
   input  wire logic [7:0]  i_a,
   input  wire logic [7:0]  i_b,
   input  wire logic        i_a_signed,
   input  wire logic        i_b_signed,
   input  wire logic        i_frac,
   output logic      [15:0] o_product,
   output logic             o_carry
);

   logic signed [8:0]  a_ext;
   logic signed [8:0]  b_ext;
   logic signed [17:0] full;
   logic        [15:0] raw;

   assign a_ext = {i_a_signed & i_a[7], i_a};
   assign b_ext = {i_b_signed & i_b[7], i_b};
   assign full  = a_ext * b_ext;
   assign raw   = full[15:0];

   // carry reports the top bit before the fractional shift drops it
   assign o_carry   = raw[15];
   assign o_product = i_frac ? {raw[14:0], 1'b0} : raw;

endmodule : mabe_mul

/* File: rtl/mabe_execute.sv */
// execute unit: alu, multiply, jumps, calls, skips and branches
module mabe_execute
   import mabe_pkg::*;
(
   input  wire logic            i_core_clk,
   input  wire logic            i_resetn,
   input  wire logic            i_valid,
   input  wire mabe_req_t       i_req,
   output logic                 o_ready,
   output logic                 o_done,
   output mabe_wb_t             o_wb,
   output logic      [7:0]      o_flags,
   output logic      [15:0]     o_pc
);

   mabe_state_t cur_reg;
   mabe_state_t cur_next;

   logic [15:0] mul_product;
   logic        mul_carry;
   logic        mul_a_signed;
   logic        mul_b_signed;
   logic        mul_frac;

   assign mul_a_signed = (i_req.op == OP_MUL_S) || (i_req.op == OP_MUL_MIX) ||
                         (i_req.op == OP_FRAC_S) || (i_req.op == OP_FRAC_MIX);
   assign mul_b_signed = (i_req.op == OP_MUL_S) || (i_req.op == OP_FRAC_S);
   assign mul_frac     = (i_req.op == OP_FRAC_U) || (i_req.op == OP_FRAC_S) ||
                         (i_req.op == OP_FRAC_MIX);

   mabe_mul u_mul (
      .i_a        (i_req.opa),
      .i_b        (i_req.opb),
      .i_a_signed (mul_a_signed),
      .i_b_signed (mul_b_signed),
      .i_frac     (mul_frac),
      .o_product  (mul_product),
      .o_carry    (mul_carry)
   );

   always_comb begin
      logic [7:0]  f;
      logic [15:0] npc;
      logic [2:0]  cyc;
      mabe_wb_t    wb;
      mabe_alu_t   r;
      logic [7:0]  lres;
      logic [16:0] w;
      logic        cond;
      f = cur_reg.flags;
      npc = cur_reg.pc + PC_STEP;
      cyc = CYC_ALU;
      wb = '0;
      r = '0;
      lres = 8'h00;
      w = 17'h0_0000;
      cond = 1'b0;
      cur_next = cur_reg;
      cur_next.done = 1'b0;
      cur_next.wb = '0;

      // flags start from the stored value
      unique case (i_req.op)
         OP_ADD, OP_ADD_CARRY: begin
            r = mabe_add8(i_req.opa, i_req.opb,
                          (i_req.op == OP_ADD_CARRY) & cur_reg.flags[FLAG_C]);
            wb.rd_we = 1'b1;
            wb.rd_data = r.res;
            f[FLAG_Z] = (r.res == 8'h00);
            f[FLAG_C] = r.c;
            f[FLAG_N] = r.res[7];
            f[FLAG_V] = r.v;
            f[FLAG_H] = r.h;
         end
         OP_SUB, OP_SUB_BORROW, OP_CMP, OP_CMP_BORROW, OP_NEG: begin
            if (i_req.op == OP_NEG) begin
               r = mabe_sub8(8'h00, i_req.opa, 1'b0);
            end else begin
               r = mabe_sub8(i_req.opa, i_req.opb,
                             ((i_req.op == OP_SUB_BORROW) ||
                              (i_req.op == OP_CMP_BORROW)) &
                             cur_reg.flags[FLAG_C]);
            end
            wb.rd_we = (i_req.op != OP_CMP) && (i_req.op != OP_CMP_BORROW);
            wb.rd_data = r.res;
            f[FLAG_Z] = (r.res == 8'h00);
            f[FLAG_C] = r.c;
            f[FLAG_N] = r.res[7];
            f[FLAG_V] = r.v;
            f[FLAG_H] = r.h;
         end
         OP_AND, OP_OR, OP_EOR, OP_CLR_MASK, OP_ZS_CHECK, OP_COM: begin
            // logic ops touch Z N V, COM also sets C
            unique case (i_req.op)
               OP_AND:      lres = i_req.opa & i_req.opb;
               OP_OR:       lres = i_req.opa | i_req.opb;
               OP_EOR:      lres = i_req.opa ^ i_req.opb;
               OP_CLR_MASK: lres = i_req.opa & (ALL_ONES - i_req.opb);
               OP_ZS_CHECK: lres = i_req.opa & i_req.opa;
               default:     lres = ALL_ONES - i_req.opa;
            endcase
            wb.rd_we = 1'b1;
            wb.rd_data = lres;
            f[FLAG_Z] = (lres == 8'h00);
            f[FLAG_N] = lres[7];
            f[FLAG_V] = 1'b0;
            if (i_req.op == OP_COM) begin
               f[FLAG_C] = 1'b1;
            end
         end
         OP_FILL_ONES: begin
            wb.rd_we = 1'b1;
            wb.rd_data = ALL_ONES;
         end
         OP_INC, OP_DEC: begin
            lres = (i_req.op == OP_INC) ? i_req.opa + 8'h01
                                        : i_req.opa - 8'h01;
            wb.rd_we = 1'b1;
            wb.rd_data = lres;
            f[FLAG_Z] = (lres == 8'h00);
            f[FLAG_N] = lres[7];
            f[FLAG_V] = (i_req.op == OP_INC) ? (lres == INC_OVF)
                                             : (lres == DEC_OVF);
         end
         OP_ADD_PAIR, OP_SUB_PAIR: begin
            if (i_req.op == OP_ADD_PAIR) begin
               w = {1'b0, i_req.word} + {11'h000, i_req.opb[5:0]};
               f[FLAG_V] = ~i_req.word[15] & w[15];
            end else begin
               w = {1'b0, i_req.word} - {11'h000, i_req.opb[5:0]};
               f[FLAG_V] = i_req.word[15] & ~w[15];
            end
            wb.pair_we = 1'b1;
            wb.pair_data = w[15:0];
            f[FLAG_C] = w[16];
            f[FLAG_N] = w[15];
            f[FLAG_Z] = (w[15:0] == 16'h0000);
            f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
            cyc = CYC_PAIR;
         end
         OP_MUL_U, OP_MUL_S, OP_MUL_MIX,
         OP_FRAC_U, OP_FRAC_S, OP_FRAC_MIX: begin
            // fractional shift is done in the multiplier
            wb.prod_we = 1'b1;
            wb.prod_data = mul_product;
            f[FLAG_C] = mul_carry;
            f[FLAG_Z] = (mul_product == 16'h0000);
            cyc = CYC_MUL;
         end
         OP_REL_JUMP: begin
            npc = mabe_rel_target(cur_reg.pc, i_req.offset);
            cyc = CYC_REL_JUMP;
         end
         OP_PTR_JUMP: begin
            npc = i_req.target;
            cyc = CYC_PTR_JUMP;
         end
         OP_DIR_JUMP: begin
            npc = i_req.target;
            cyc = CYC_DIR_JUMP;
         end
         OP_REL_CALL: begin
            wb.push_we = 1'b1;
            wb.push_addr = cur_reg.pc + PC_STEP;
            npc = mabe_rel_target(cur_reg.pc, i_req.offset);
            cyc = CYC_REL_CALL;
         end
         OP_PTR_CALL: begin
            wb.push_we = 1'b1;
            wb.push_addr = cur_reg.pc + PC_STEP;
            npc = i_req.target;
            cyc = CYC_PTR_CALL;
         end
         OP_DIR_CALL: begin
            // two-word call returns past its address word
            wb.push_we = 1'b1;
            wb.push_addr = cur_reg.pc + PC_CALL_LONG;
            npc = i_req.target;
            cyc = CYC_DIR_CALL;
         end
         OP_RETURN, OP_INT_RETURN: begin
            // pc from stack, interrupt return sets I
            wb.pop = 1'b1;
            npc = i_req.target;
            cyc = CYC_RETURN;
            if (i_req.op == OP_INT_RETURN) begin
               f[FLAG_I] = 1'b1;
            end
         end
         OP_CMP_SKIP, OP_SKIP_REG_LOW, OP_SKIP_REG_HIGH,
         OP_SKIP_IO_LOW, OP_SKIP_IO_HIGH: begin
            unique case (i_req.op)
               OP_CMP_SKIP:      cond = (i_req.opa == i_req.opb);
               OP_SKIP_REG_LOW:  cond = ~i_req.opa[i_req.bit_sel];
               OP_SKIP_REG_HIGH: cond = i_req.opa[i_req.bit_sel];
               OP_SKIP_IO_LOW:   cond = ~i_req.opb[i_req.bit_sel];
               default:          cond = i_req.opb[i_req.bit_sel];
            endcase
            // skipping a two-word instruction costs one more cycle
            if (cond) begin
               npc = cur_reg.pc + (i_req.next_long ? PC_SKIP_LONG
                                                   : PC_SKIP_SHORT);
               cyc = i_req.next_long ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
            end
         end
         OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
         OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT: begin
            unique case (i_req.op)
               // Z, N and V picked by bit select
               // H and T picked the same way
               OP_BRANCH_FLAG_HIGH: cond = cur_reg.flags[i_req.bit_sel];
               OP_BRANCH_FLAG_LOW:  cond = ~cur_reg.flags[i_req.bit_sel];
               // signed compare on N xor V
               OP_BRANCH_SIGNED_GE:
                  cond = ~(cur_reg.flags[FLAG_N] ^ cur_reg.flags[FLAG_V]);
               default:
                  cond = cur_reg.flags[FLAG_N] ^ cur_reg.flags[FLAG_V];
            endcase
            if (cond) begin
               npc = mabe_rel_target(cur_reg.pc, i_req.offset);
               cyc = CYC_BR_TAKEN;
            end
         end
      endcase

      unique case (cur_reg.state)
         ST_IDLE: begin
            if (i_valid) begin
               if (cyc == CYC_ALU) begin
                  cur_next.flags = f;
                  cur_next.pc = npc;
                  cur_next.wb = wb;
                  cur_next.done = 1'b1;
               end else begin
                  cur_next.pend_flags = f;
                  cur_next.pend_pc = npc;
                  cur_next.pend_wb = wb;
                  cur_next.cnt = cyc - 3'h1;
                  cur_next.state = ST_BUSY;
               end
            end
         end
         ST_BUSY: begin
            // results land together on the last cycle of the operation
            cur_next.cnt = cur_reg.cnt - 3'h1;
            if (cur_reg.cnt == 3'h1) begin
               cur_next.flags = cur_reg.pend_flags;
               cur_next.pc = cur_reg.pend_pc;
               cur_next.wb = cur_reg.pend_wb;
               cur_next.done = 1'b1;
               cur_next.state = ST_IDLE;
            end
         end
         default: begin
            cur_next.state = ST_IDLE;
            cur_next.cnt = 3'h0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cur_reg <= '0;
         cur_reg.state <= ST_IDLE;
         cur_reg.flags <= FLAGS_RESET;
         cur_reg.pc <= PC_RESET;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ready is combinational so a one-cycle op can follow each cycle
   assign o_ready = (cur_reg.state == ST_IDLE);
   assign o_done  = cur_reg.done;
   assign o_wb    = cur_reg.wb;
   assign o_flags = cur_reg.flags;
   assign o_pc    = cur_reg.pc;

endmodule : mabe_execute

/* File: verification/mabe_execute_monitor.sv */
// assertion checker for the execute unit ports
module mabe_execute_monitor
   import mabe_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_resetn,
   input wire logic        i_valid,
   input wire mabe_req_t   i_req,
   input wire logic        o_ready,
   input wire logic        o_done,
   input wire mabe_wb_t    o_wb,
   input wire logic [7:0]  o_flags,
   input wire logic [15:0] o_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        take;
   logic [15:0] rel_reg;
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   assign take = i_valid && o_ready;
   // target latched at take, the request bus is free to move afterwards
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rel_reg <= 16'h0000;
      end else if (take) begin
         rel_reg <= o_pc + {{4{i_req.offset[11]}}, i_req.offset} + 16'h0001;
      end
   end
   sequence s_busy;
      !o_ready && !o_done;
   endsequence
   add_result_a:
      assert property (take && i_req.op == OP_ADD |=> o_done && o_wb.rd_we
         && o_wb.rd_data == 8'($past(i_req.opa) + $past(i_req.opb)))
      else $error("add result wrong");
   pair_timing_a:
      assert property (take && i_req.op inside {OP_ADD_PAIR, OP_SUB_PAIR}
         |=> s_busy ##1 (o_done && o_wb.pair_we))
      else $error("pair op timing wrong");
   sub_result_a:
      assert property (take && i_req.op == OP_SUB |=> o_done && o_wb.rd_we
         && o_wb.rd_data == 8'($past(i_req.opa) - $past(i_req.opb)))
      else $error("sub result wrong");
   logic_flags_a:
      assert property (take && i_req.op inside {OP_AND, OP_OR, OP_EOR}
         |=> o_flags[FLAG_C] == $past(o_flags[FLAG_C])
         && o_flags[FLAG_Z] == (o_wb.rd_data == 8'h00))
      else $error("logic op flags wrong");
   fill_ones_a:
      assert property (take && i_req.op == OP_FILL_ONES
         |=> o_wb.rd_data == ALL_ONES && o_flags == $past(o_flags))
      else $error("fill ones wrong");
   mul_product_a:
      assert property (take && i_req.op == OP_MUL_U |=> s_busy ##1
         (o_done && o_wb.prod_we && o_wb.prod_data ==
         {8'h00, $past(i_req.opa, 2)} * {8'h00, $past(i_req.opb, 2)}))
      else $error("product wrong");
   ptr_jump_a:
      assert property (take && i_req.op == OP_PTR_JUMP
         |=> s_busy ##1 (o_done && o_pc == $past(i_req.target, 2)))
      else $error("pointer jump wrong");
   int_return_a:
      assert property (take && i_req.op == OP_INT_RETURN |=> s_busy [*3]
         ##1 (o_done && o_wb.pop && o_flags[FLAG_I]
         && o_pc == $past(i_req.target, 4)))
      else $error("interrupt return wrong");
   cmp_discard_a:
      assert property (take && i_req.op == OP_CMP |=> o_done && !o_wb.rd_we
         && o_flags[FLAG_Z] == ($past(i_req.opa) == $past(i_req.opb)))
      else $error("compare wrong");
   signed_lt_a:
      assert property (take && i_req.op == OP_BRANCH_SIGNED_LT
         && (o_flags[FLAG_N] ^ o_flags[FLAG_V])
         |=> s_busy ##1 (o_done && o_pc == rel_reg))
      else $error("signed branch wrong");
endmodule : mabe_execute_monitor

bind mabe_execute mabe_execute_monitor u_mabe_execute_monitor (
   .i_core_clk, .i_resetn, .i_valid, .i_req,
   .o_ready, .o_done, .o_wb, .o_flags, .o_pc
);

/* File: verification/test_mcu_alu_and_branch_execute.sv */
// self-checking bench for the execute unit
module test_mcu_alu_and_branch_execute
   import mabe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk = 1'b0;
   logic        i_resetn   = 1'b0;
   logic        i_valid    = 1'b0;
   mabe_req_t   i_req      = '0;
   logic        o_ready;
   logic        o_done;
   mabe_wb_t    o_wb;
   logic [7:0]  o_flags;
   logic [15:0] o_pc;
   mabe_wb_t    wb;
   logic [15:0] bpc;
   int          cyc;
   int          num_errors = 0;
   int          compares   = 0;

   always #5 i_core_clk = ~i_core_clk;

   mabe_execute u_mabe_execute (
      .i_core_clk, .i_resetn, .i_valid, .i_req,
      .o_ready, .o_done, .o_wb, .o_flags, .o_pc
   );

   task automatic chk(input string n, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one request, then count cycles up to done; bounded so a hang shows
   task automatic go(input mabe_op_t op, input logic [7:0] a, b,
                     input logic [15:0] t = 16'h0000,
                     input logic [11:0] k = 12'h000,
                     input logic [2:0] s = 3'h0, input logic nl = 1'b0);
      mabe_req_t r;
      r = '0;
      r.op = op;
      r.opa = a;
      r.opb = b;
      r.word = t;
      r.target = t;
      r.offset = k;
      r.bit_sel = s;
      r.next_long = nl;
      @(posedge i_core_clk);
      i_valid <= 1'b1;
      i_req <= r;
      @(posedge i_core_clk);
      i_valid <= 1'b0;
      cyc = 1;
      @(negedge i_core_clk);
      while (o_done !== 1'b1 && cyc < 8) begin
         @(negedge i_core_clk);
         cyc++;
      end
      wb = o_wb;
   endtask : go

   task automatic post(input logic [15:0] n, e, g, input logic [7:0] f);
      chk("cycles", n, 16'(cyc));
      chk("data", e, g);
      chk("flags", {8'h00, f}, {8'h00, o_flags});
   endtask : post

   task automatic alu(input mabe_op_t op, input logic [7:0] a, b, r, f);
      go(op, a, b);
      post(16'h0001, {8'h00, r}, {8'h00, wb.rd_data}, f);
   endtask : alu

   task automatic flow(input mabe_op_t op, input logic [15:0] t,
                       input logic [11:0] k, input logic [15:0] n, pc, ps,
                       input logic [7:0] f);
      go(op, 8'h00, 8'h00, t, k);
      post(n, pc, o_pc, f);
      chk("push", ps, wb.push_we ? wb.push_addr : 16'h0000);
   endtask : flow

   task automatic sk(input mabe_op_t op, input logic [7:0] a, b,
                     input logic nl, input logic [15:0] n, pc);
      go(op, a, b, 16'h0000, 12'h000, 3'h0, nl);
      post(n, pc, o_pc, 8'h96);
   endtask : sk

   task automatic br(input mabe_op_t op, input logic [2:0] s,
                     input logic tk, input logic [7:0] f);
      go(op, 8'h00, 8'h00, 16'h0000, 12'h004, s);
      bpc = tk ? bpc + 16'h0005 : bpc + 16'h0001;
      post(tk ? 16'h0002 : 16'h0001, bpc, o_pc, f);
   endtask : br

   task automatic cmpf(input logic [7:0] a, b, f);
      go(OP_CMP, a, b);
      bpc = bpc + 16'h0001;
      post(16'h0001, bpc, o_pc, f);
      chk("write", 16'h0000, {15'h0000, wb.rd_we});
   endtask : cmpf

   task automatic sweep(input logic [7:0] f);
      for (int s = 0; s < 8; s++) begin
         br(OP_BRANCH_FLAG_HIGH, 3'(s), f[s], f);
         br(OP_BRANCH_FLAG_LOW, 3'(s), !f[s], f);
      end
   endtask : sweep

   task automatic t_reset;
      @(negedge i_core_clk);
      chk("ready", 16'h0001, {15'h0000, o_ready});
      chk("flags", 16'h0000, {8'h00, o_flags});
      chk("pc", 16'h0000, o_pc);
   endtask : t_reset

   task automatic t_alu;
      alu(OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h20);
      alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h23);
      alu(OP_ADD_CARRY, 8'h01, 8'h01, 8'h03, 8'h00);
      alu(OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h25);
      alu(OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h23);
      alu(OP_OR, 8'h80, 8'h01, 8'h81, 8'h25);
      alu(OP_EOR, 8'h81, 8'h81, 8'h00, 8'h23);
      alu(OP_CLR_MASK, 8'hF3, 8'h0F, 8'hF0, 8'h25);
      alu(OP_FILL_ONES, 8'h00, 8'h00, 8'hFF, 8'h25);
      alu(OP_SUB_BORROW, 8'h05, 8'h02, 8'h02, 8'h00);
      alu(OP_INC, 8'h7F, 8'h00, 8'h80, 8'h0C);
      alu(OP_DEC, 8'h80, 8'h00, 8'h7F, 8'h08);
      alu(OP_ZS_CHECK, 8'h00, 8'h00, 8'h00, 8'h02);
      alu(OP_COM, 8'h0F, 8'h00, 8'hF0, 8'h05);
      alu(OP_NEG, 8'h80, 8'h00, 8'h80, 8'h0D);
      go(OP_CMP_BORROW, 8'h05, 8'h04);
      post(16'h0001, 16'h0000, {15'h0000, wb.rd_we}, 8'h02);
   endtask : t_alu

   task automatic t_pair_mul;
      go(OP_ADD_PAIR, 8'h00, 8'h01, 16'hFFFF);
      post(16'h0002, 16'h0000, wb.pair_data, 8'h03);
      go(OP_SUB_PAIR, 8'h00, 8'h01, 16'h0000);
      post(16'h0002, 16'hFFFF, wb.pair_data, 8'h15);
      go(OP_MUL_U, 8'hFF, 8'hFF);
      post(16'h0002, 16'hFE01, wb.prod_data, 8'h15);
      go(OP_MUL_S, 8'hFF, 8'hFF);
      post(16'h0002, 16'h0001, wb.prod_data, 8'h14);
      go(OP_MUL_MIX, 8'hFF, 8'h02);
      post(16'h0002, 16'hFFFE, wb.prod_data, 8'h15);
      go(OP_FRAC_U, 8'h80, 8'h80);
      post(16'h0002, 16'h8000, wb.prod_data, 8'h14);
      go(OP_FRAC_MIX, 8'hFF, 8'h80);
      post(16'h0002, 16'hFF00, wb.prod_data, 8'h15);
      go(OP_FRAC_S, 8'h80, 8'h80);
      post(16'h0002, 16'h8000, wb.prod_data, 8'h14);
      go(OP_MUL_U, 8'h00, 8'h05);
      post(16'h0002, 16'h0000, wb.prod_data, 8'h16);
   endtask : t_pair_mul

   task automatic t_flow;
      flow(OP_PTR_JUMP, 16'h0100, 12'h000, 2, 16'h0100, 0, 8'h16);
      flow(OP_REL_JUMP, 16'h0000, 12'hFFE, 2, 16'h00FF, 0, 8'h16);
      flow(OP_DIR_JUMP, 16'h1234, 12'h000, 3, 16'h1234, 0, 8'h16);
      flow(OP_REL_CALL, 16'h0, 12'h010, 3, 16'h1245, 16'h1235, 8'h16);
      flow(OP_DIR_CALL, 16'h0400, 12'h0, 4, 16'h0400, 16'h1247, 8'h16);
      flow(OP_PTR_CALL, 16'h0500, 12'h0, 3, 16'h0500, 16'h0401, 8'h16);
      flow(OP_RETURN, 16'h0200, 12'h000, 4, 16'h0200, 0, 8'h16);
      flow(OP_INT_RETURN, 16'h0300, 12'h0, 4, 16'h0300, 0, 8'h96);
   endtask : t_flow

   task automatic t_skip;
      sk(OP_CMP_SKIP, 8'h05, 8'h05, 1'b0, 2, 16'h0302);
      sk(OP_CMP_SKIP, 8'h05, 8'h05, 1'b1, 3, 16'h0305);
      sk(OP_CMP_SKIP, 8'h05, 8'h06, 1'b0, 1, 16'h0306);
      sk(OP_SKIP_REG_LOW, 8'hFE, 8'h00, 1'b0, 2, 16'h0308);
      sk(OP_SKIP_REG_HIGH, 8'hFE, 8'h00, 1'b0, 1, 16'h0309);
      sk(OP_SKIP_IO_LOW, 8'h00, 8'h01, 1'b0, 1, 16'h030A);
      sk(OP_SKIP_IO_HIGH, 8'h00, 8'h01, 1'b1, 3, 16'h030D);
   endtask : t_skip

   task automatic t_branch;
      flow(OP_PTR_JUMP, 16'h0400, 12'h000, 2, 16'h0400, 0, 8'h96);
      bpc = 16'h0400;
      cmpf(8'h05, 8'h05, 8'h92);
      cmpf(8'h01, 8'h02, 8'hB5);
      sweep(8'hB5);
      br(OP_BRANCH_SIGNED_LT, 3'h0, 1'b1, 8'hB5);
      br(OP_BRANCH_SIGNED_GE, 3'h0, 1'b0, 8'hB5);
      cmpf(8'h01, 8'h80, 8'h9D);
      br(OP_BRANCH_SIGNED_LT, 3'h0, 1'b0, 8'h9D);
      br(OP_BRANCH_SIGNED_GE, 3'h0, 1'b1, 8'h9D);
      sweep(8'h9D);
   endtask : t_branch

   // reset in mid-run must bring back idle state and a clean first op
   task automatic t_mid_reset;
      @(posedge i_core_clk);
      i_resetn <= 1'b0;
      t_reset();
      chk("done", 16'h0000, {15'h0000, o_done});
      chk("wb", 16'h0000, {15'h0000, |o_wb});
      @(posedge i_core_clk);
      i_resetn <= 1'b1;
      alu(OP_INC, 8'h00, 8'h00, 8'h01, 8'h00);
      chk("pc", 16'h0001, o_pc);
   endtask : t_mid_reset

   task automatic report_and_stop;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   // whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge i_core_clk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge i_core_clk);
      t_reset();
      @(posedge i_core_clk);
      i_resetn <= 1'b1;
      t_alu();
      t_pair_mul();
      t_flow();
      t_skip();
      t_branch();
      t_mid_reset();
      report_and_stop();
   end
endmodule : test_mcu_alu_and_branch_execute
